// *** logic/cpu_register_set.sv ***
// Core register set: general, control and system registers, operand
// extension, alignment checks, literal-pool addressing and event interrupt.
// Assumes the pipeline and the register bus both run on mclk_i.
//
// Function
// - Sixteen 32-bit general registers for data, addresses
// - Register zero is the index register
// - Register fifteen is exception stack pointer
// - Status word, global base, vector base control registers
// - Global base feeds peripheral indirect addressing
// - Vector base locates exception vector area
// - Accumulator pair holds multiply results; program counter
// - Link register holds subroutine return address
// - Reset loads stack pointer, counter from table
// - Reset sets interrupt mask ones, reserved zero
// - Reset clears vector base
// - Byte and halfword loads are sign-extended
// - Misaligned halfword or longword raises address error
// - Stack holds aligned longwords only
// - Move, add, compare-equal immediates sign-extended
// - Test and logic immediates zero-extended
// - Wider constants come from counter-relative table
module cpu_register_set (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  input wire cpu_regs_pkg::wb_req_t wb_i,
  input wire cpu_regs_pkg::ctl_req_t ctl_i,
  input wire logic mac_we_i,
  input wire logic [63:0] mac_result_i,
  input wire logic call_i,
  input wire logic [31:0] call_ret_i,
  input wire logic pc_we_i,
  input wire logic [31:0] pc_next_i,
  input wire logic boot_load_i,
  input wire logic [31:0] boot_sp_i,
  input wire logic [31:0] boot_pc_i,
  input wire logic exc_push_i,
  input wire logic exc_pop_i,
  input wire cpu_regs_pkg::acc_req_t acc_i,
  input wire cpu_regs_pkg::imm_req_t imm_i,
  input wire cpu_regs_pkg::lit_req_t lit_i,
  input wire logic [3:0] rd_a_idx_i,
  input wire logic [3:0] rd_b_idx_i,
  output logic [31:0] rd_a_o,
  output logic [31:0] rd_b_o,
  output logic [31:0] index_o,
  output logic [31:0] sp_o,
  output logic [31:0] status_o,
  output logic [31:0] gbase_o,
  output logic [31:0] vbase_o,
  output logic [31:0] acch_o,
  output logic [31:0] accl_o,
  output logic [31:0] link_o,
  output logic [31:0] pc_o,
  output logic [31:0] imm_ext_o,
  output logic [31:0] lit_addr_o,
  output logic addr_err_o,
  output logic irq_o
);

  cpu_regs_pkg::state_t s_q;
  cpu_regs_pkg::state_t s_d;
  logic [31:0] wb_val;
  logic [cpu_regs_pkg::EVT_W-1:0] evt_set;
  logic [cpu_regs_pkg::EVT_W-1:0] evt_clr;
  logic mis_align;
  logic stack_err;
  logic bus_gpr_hit;
  logic [3:0] bus_gpr_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Operand shaping

  always_comb begin
    case (wb_i.kind)
      cpu_regs_pkg::WB_MEM_BYTE: wb_val = {{24{wb_i.data[7]}}, wb_i.data[7:0]};
      cpu_regs_pkg::WB_MEM_HALF: wb_val = {{16{wb_i.data[15]}}, wb_i.data[15:0]};
      cpu_regs_pkg::WB_IMM_ARITH: wb_val = {{24{wb_i.data[7]}}, wb_i.data[7:0]};
      cpu_regs_pkg::WB_IMM_LOGIC: wb_val = {24'h00_0000, wb_i.data[7:0]};
      default: wb_val = wb_i.data;
    endcase
  end

  // Data of a faulting access is not guaranteed; only the flag is.
  always_comb begin
    case (acc_i.size)
      cpu_regs_pkg::SZ_HALF: mis_align = acc_i.addr[0];
      cpu_regs_pkg::SZ_LONG: mis_align = |acc_i.addr[1:0];
      default: mis_align = 1'b0;
    endcase
  end

  // Stack frames are longwords; a misaligned pointer on push or pop is flagged
  assign stack_err = (acc_i.valid && acc_i.stack && acc_i.size != cpu_regs_pkg::SZ_LONG)
    || ((exc_push_i || exc_pop_i) && |s_q.gpr[cpu_regs_pkg::SP_IDX][1:0]);

  assign bus_gpr_hit = bus_addr_i <= cpu_regs_pkg::OFS_GPR_LAST && bus_addr_i[1:0] == 2'b00;
  assign bus_gpr_idx = bus_addr_i[5:2];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    evt_set = '0;
    evt_clr = '0;

    // Bus writes first so that a same-cycle pipeline update wins
    if (bus_wr_i) begin
      if (bus_gpr_hit) begin
        s_d.gpr[bus_gpr_idx] = bus_wdata_i;
      end else begin
        case (bus_addr_i)
          cpu_regs_pkg::OFS_STATUS: s_d.sr = bus_wdata_i & cpu_regs_pkg::SR_WRITABLE;
          cpu_regs_pkg::OFS_GBASE: s_d.gbase = bus_wdata_i;
          cpu_regs_pkg::OFS_VBASE: s_d.vbase = bus_wdata_i;
          cpu_regs_pkg::OFS_ACCH: s_d.acch = bus_wdata_i;
          cpu_regs_pkg::OFS_ACCL: s_d.accl = bus_wdata_i;
          cpu_regs_pkg::OFS_LINK: s_d.link = bus_wdata_i;
          cpu_regs_pkg::OFS_EVT_MASK: s_d.evt_mask = bus_wdata_i[cpu_regs_pkg::EVT_W-1:0];
          default: s_d.evt_mask = s_q.evt_mask;
        endcase
      end
    end

    if (wb_i.en) begin
      s_d.gpr[wb_i.idx] = wb_val;
    end

    if (ctl_i.en) begin
      case (ctl_i.sel)
        cpu_regs_pkg::CTL_STATUS: s_d.sr = ctl_i.data & cpu_regs_pkg::SR_WRITABLE;
        cpu_regs_pkg::CTL_GBASE: s_d.gbase = ctl_i.data;
        cpu_regs_pkg::CTL_VBASE: s_d.vbase = ctl_i.data;
        cpu_regs_pkg::CTL_ACCH: s_d.acch = ctl_i.data;
        cpu_regs_pkg::CTL_ACCL: s_d.accl = ctl_i.data;
        cpu_regs_pkg::CTL_LINK: s_d.link = ctl_i.data;
        default: s_d.sr = s_q.sr;
      endcase
    end

    if (mac_we_i) begin
      s_d.acch = mac_result_i[63:32];
      s_d.accl = mac_result_i[31:0];
    end

    if (call_i) begin
      s_d.link = call_ret_i;
    end

    if (pc_we_i) begin
      s_d.pc = pc_next_i;
    end

    // Exception frames move the pointer by whole frames
    if (exc_push_i) begin
      s_d.gpr[cpu_regs_pkg::SP_IDX] =
        s_q.gpr[cpu_regs_pkg::SP_IDX] - cpu_regs_pkg::EXC_FRAME_BYTES;
    end else if (exc_pop_i) begin
      s_d.gpr[cpu_regs_pkg::SP_IDX] =
        s_q.gpr[cpu_regs_pkg::SP_IDX] + cpu_regs_pkg::EXC_FRAME_BYTES;
    end

    // Vector table fetch after reset has the last word
    if (boot_load_i) begin
      s_d.gpr[cpu_regs_pkg::SP_IDX] = boot_sp_i;
      s_d.pc = boot_pc_i;
    end

    if (s_d.gpr[cpu_regs_pkg::SP_IDX][1:0] != 2'b00 && boot_load_i) begin
      evt_set[cpu_regs_pkg::EVT_STACK_ERR] = 1'b1;
    end

    // Side results, one cycle behind their requests
    s_d.rd_a = s_d.gpr[rd_a_idx_i];
    s_d.rd_b = s_d.gpr[rd_b_idx_i];
    s_d.imm_ext = imm_i.logic_op ? {24'h00_0000, imm_i.val}
                                 : {{24{imm_i.val[7]}}, imm_i.val};
    // Only byte immediates live in the opcode; wider ones use this address
    if (lit_i.is_long) begin
      s_d.lit_addr = {s_q.pc[31:2], 2'b00} + cpu_regs_pkg::PIPE_PC_AHEAD
        + {22'h00_0000, lit_i.disp, 2'b00};
    end else begin
      s_d.lit_addr = s_q.pc + cpu_regs_pkg::PIPE_PC_AHEAD
        + {23'h00_0000, lit_i.disp, 1'b0};
    end

    s_d.addr_err = (acc_i.valid && mis_align) || stack_err;
    if (acc_i.valid && mis_align) begin
      evt_set[cpu_regs_pkg::EVT_ADDR_ERR] = 1'b1;
    end
    if (stack_err) begin
      evt_set[cpu_regs_pkg::EVT_STACK_ERR] = 1'b1;
    end

    // Register bus read data, valid the cycle after the strobe only
    s_d.bus_rdata = 32'h0000_0000;
    if (bus_rd_i) begin
      if (bus_gpr_hit) begin
        s_d.bus_rdata = s_q.gpr[bus_gpr_idx];
      end else begin
        case (bus_addr_i)
          cpu_regs_pkg::OFS_STATUS: s_d.bus_rdata = s_q.sr;
          cpu_regs_pkg::OFS_GBASE: s_d.bus_rdata = s_q.gbase;
          cpu_regs_pkg::OFS_VBASE: s_d.bus_rdata = s_q.vbase;
          cpu_regs_pkg::OFS_ACCH: s_d.bus_rdata = s_q.acch;
          cpu_regs_pkg::OFS_ACCL: s_d.bus_rdata = s_q.accl;
          cpu_regs_pkg::OFS_LINK: s_d.bus_rdata = s_q.link;
          cpu_regs_pkg::OFS_PC: s_d.bus_rdata = s_q.pc;
          cpu_regs_pkg::OFS_EVT: begin
            s_d.bus_rdata = {30'h0000_0000, s_q.evt};
            evt_clr = s_q.evt;
          end
          cpu_regs_pkg::OFS_EVT_MASK: s_d.bus_rdata = {30'h0000_0000, s_q.evt_mask};
          default: s_d.bus_rdata = 32'h0000_0000;
        endcase
      end
    end

    // A new event in the clearing cycle stays set
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;
    s_d.irq = |(s_d.evt & s_d.evt_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; fields with an undefined reset value keep no reset

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.sr <= cpu_regs_pkg::SR_RST;
      s_q.vbase <= cpu_regs_pkg::VBASE_RST;
      s_q.evt <= '0;
      s_q.evt_mask <= '0;
      s_q.bus_rdata <= 32'h0000_0000;
      s_q.rd_a <= 32'h0000_0000;
      s_q.rd_b <= 32'h0000_0000;
      s_q.imm_ext <= 32'h0000_0000;
      s_q.lit_addr <= 32'h0000_0000;
      s_q.addr_err <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.pc <= 32'h0000_0000;
      s_q.gpr[cpu_regs_pkg::SP_IDX] <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata_o = s_q.bus_rdata;
  assign rd_a_o = s_q.rd_a;
  assign rd_b_o = s_q.rd_b;
  assign index_o = s_q.gpr[cpu_regs_pkg::INDEX_IDX];
  assign sp_o = s_q.gpr[cpu_regs_pkg::SP_IDX];
  assign status_o = s_q.sr;
  assign gbase_o = s_q.gbase;
  assign vbase_o = s_q.vbase;
  assign acch_o = s_q.acch;
  assign accl_o = s_q.accl;
  assign link_o = s_q.link;
  assign pc_o = s_q.pc;
  assign imm_ext_o = s_q.imm_ext;
  assign lit_addr_o = s_q.lit_addr;
  assign addr_err_o = s_q.addr_err;
  assign irq_o = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_VBASE_RESET: assert property ($rose(rst_b_i) |-> vbase_o == cpu_regs_pkg::VBASE_RST)
    else $error("vector base not cleared by reset");

  AST_IMASK_RESET: assert property ($rose(rst_b_i) |->
    status_o[cpu_regs_pkg::SR_IMASK_LSB +: 4] == cpu_regs_pkg::IMASK_RST
    && (status_o & ~cpu_regs_pkg::SR_WRITABLE) == 32'h0000_0000)
    else $error("status word reset value wrong");

  AST_STATUS_RSVD: assert property (
    (status_o & ~cpu_regs_pkg::SR_WRITABLE) == 32'h0000_0000)
    else $error("status word has a reserved bit set");

  AST_BYTE_SIGN: assert property (wb_i.en && wb_i.kind == cpu_regs_pkg::WB_MEM_BYTE
    && wb_i.idx == 4'h3 |=> s_q.gpr[3] == {{24{$past(wb_i.data[7])}}, $past(wb_i.data[7:0])})
    else $error("byte load not sign-extended");

  AST_HALF_MISALIGN: assert property (acc_i.valid && acc_i.size == cpu_regs_pkg::SZ_HALF
    && acc_i.addr[0] |=> addr_err_o && s_q.evt[cpu_regs_pkg::EVT_ADDR_ERR])
    else $error("misaligned halfword not flagged");

  AST_BYTE_ANY: assert property (acc_i.valid && acc_i.size == cpu_regs_pkg::SZ_BYTE
    && !acc_i.stack && !exc_push_i && !exc_pop_i |=> !addr_err_o)
    else $error("byte access flagged");

  AST_STACK_LONG: assert property (acc_i.valid && acc_i.stack
    && acc_i.size != cpu_regs_pkg::SZ_LONG |=> addr_err_o && s_q.evt[1])
    else $error("non-longword stack access not flagged");

  AST_IMM_ARITH: assert property (!imm_i.logic_op |=>
    imm_ext_o == {{24{$past(imm_i.val[7])}}, $past(imm_i.val)})
    else $error("arithmetic immediate not sign-extended");

  AST_IMM_LOGIC: assert property (imm_i.logic_op |=> imm_ext_o[31:8] == 24'h00_0000
    && imm_ext_o[7:0] == $past(imm_i.val))
    else $error("logic immediate not zero-extended");

  AST_BOOT: assert property (boot_load_i |=> sp_o == $past(boot_sp_i)
    && pc_o == $past(boot_pc_i))
    else $error("boot load of pointer and counter missing");

  AST_PUSH: assert property (exc_push_i && !boot_load_i |=>
    sp_o == $past(sp_o) - cpu_regs_pkg::EXC_FRAME_BYTES)
    else $error("stack pointer not lowered by a frame");

  AST_POP: assert property (exc_pop_i && !exc_push_i && !boot_load_i |=>
    sp_o == $past(sp_o) + cpu_regs_pkg::EXC_FRAME_BYTES)
    else $error("stack pointer not raised by a frame");

  // Bus writes must never reach the counter; only the pipeline moves it
  AST_PC_HOLD: assert property (!pc_we_i && !boot_load_i |=> $stable(pc_o))
    else $error("program counter moved without a pipeline write");

  AST_LIT_LONG: assert property (lit_i.is_long |=> lit_addr_o[1:0] == 2'b00)
    else $error("long literal address not longword aligned");

  AST_MAC: assert property (mac_we_i |=> {acch_o, accl_o} == $past(mac_result_i))
    else $error("accumulator pair not loaded");

  AST_LINK: assert property (call_i |=> link_o == $past(call_ret_i))
    else $error("return address not kept");

  CVR_BOOT: cover property (boot_load_i ##[1:4] exc_push_i ##[1:20] exc_pop_i);
  CVR_STACK_ERR: cover property (exc_push_i && sp_o[1:0] != 2'b00 ##1 addr_err_o);
  CVR_LIT_MIX: cover property (lit_i.is_long ##1 !lit_i.is_long);
  CVR_MISALIGN_IRQ: cover property (acc_i.valid && acc_i.addr[0] ##1 addr_err_o ##[1:5] irq_o);
  CVR_EVT_READ: cover property (bus_rd_i && bus_addr_i == cpu_regs_pkg::OFS_EVT && s_q.evt != '0);

endmodule

// *** logic/cpu_regs_pkg.sv ***
// Package for the core register set: bus offsets, field layouts, reset values,
// request carriers and the register set's state record.
// Assumes one clock domain and a single asynchronous active-low reset.
package cpu_regs_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned GPR_CNT = 16;

  // Register bus word offsets
  localparam logic [7:0] OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] OFS_GPR_LAST = 8'h3C;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_GBASE = 8'h44;
  localparam logic [7:0] OFS_VBASE = 8'h48;
  localparam logic [7:0] OFS_ACCH = 8'h4C;
  localparam logic [7:0] OFS_ACCL = 8'h50;
  localparam logic [7:0] OFS_LINK = 8'h54;
  localparam logic [7:0] OFS_PC = 8'h58;
  localparam logic [7:0] OFS_EVT = 8'h5C;
  localparam logic [7:0] OFS_EVT_MASK = 8'h60;

  // Status word layout
  localparam int unsigned SR_IMASK_LSB = 4;
  localparam logic [31:0] SR_WRITABLE = 32'h0000_03F3;
  localparam logic [31:0] SR_RST = 32'h0000_00F0;
  localparam logic [3:0] IMASK_RST = 4'hF;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;

  localparam logic [3:0] INDEX_IDX = 4'h0;
  localparam logic [3:0] SP_IDX = 4'hF;
  // Saved program counter plus status word
  localparam logic [31:0] EXC_FRAME_BYTES = 32'h0000_0008;
  localparam logic [31:0] PIPE_PC_AHEAD = 32'h0000_0004;

  // Event status bits
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_ADDR_ERR = 0;
  localparam int unsigned EVT_STACK_ERR = 1;

  typedef enum logic [2:0] {
    WB_LONG = 3'h0,
    WB_MEM_BYTE = 3'h1,
    WB_MEM_HALF = 3'h2,
    WB_IMM_ARITH = 3'h3,
    WB_IMM_LOGIC = 3'h4
  } wb_kind_t;

  typedef enum logic [2:0] {
    CTL_STATUS = 3'h0,
    CTL_GBASE = 3'h1,
    CTL_VBASE = 3'h2,
    CTL_ACCH = 3'h3,
    CTL_ACCL = 3'h4,
    CTL_LINK = 3'h5
  } ctl_sel_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_LONG = 2'h2
  } acc_size_t;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    wb_kind_t kind;
    logic [31:0] data;
  } wb_req_t;

  typedef struct packed {
    logic en;
    ctl_sel_t sel;
    logic [31:0] data;
  } ctl_req_t;

  typedef struct packed {
    logic valid;
    logic stack;
    acc_size_t size;
    logic [31:0] addr;
  } acc_req_t;

  typedef struct packed {
    logic logic_op;
    logic [7:0] val;
  } imm_req_t;

  typedef struct packed {
    logic is_long;
    logic [7:0] disp;
  } lit_req_t;

  typedef struct packed {
    logic [15:0][31:0] gpr;
    logic [31:0] sr;
    logic [31:0] gbase;
    logic [31:0] vbase;
    logic [31:0] acch;
    logic [31:0] accl;
    logic [31:0] link;
    logic [31:0] pc;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_mask;
    logic [31:0] bus_rdata;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [31:0] imm_ext;
    logic [31:0] lit_addr;
    logic addr_err;
    logic irq;
  } state_t;

endpackage

// *** verification/cpu_register_set_bench.sv ***
// Self-checking bench for the core register set over bus and pipeline ports.
// Assumes pipe_model as the pipeline partner and the package in logic/.
module cpu_register_set_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ra_idx = 4'h3;
  logic [3:0] rb_idx = 4'h0;
  logic [31:0] rdata, rd_a, rd_b, index, sp, status, gbase, vbase, acch, accl, link, pc;
  logic [31:0] imm_ext, lit_addr, got;
  logic addr_err, irq;
  logic [63:0] val;
  logic [5:0] pulse;
  cpu_regs_pkg::wb_req_t wb;
  cpu_regs_pkg::ctl_req_t ctl;
  cpu_regs_pkg::acc_req_t acc;
  cpu_regs_pkg::imm_req_t imm;
  cpu_regs_pkg::lit_req_t lit;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] din [5] = '{32'h8000_0081, 32'h1234_5680, 32'h0000_8001, 32'h0000_01FF,
    32'h0000_FF80};
  logic [31:0] dex [5] = '{32'h8000_0081, 32'hFFFF_FF80, 32'hFFFF_8001, 32'hFFFF_FFFF,
    32'h0000_0080};
  logic ast [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [1:0] asz [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [31:0] aad [6] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0002, 32'h0000_0002,
    32'h0000_0004, 32'h0000_0004};
  logic aer [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  always #4 mclk = ~mclk;

  pipe_model pm (.mclk_i(mclk), .wb_o(wb), .ctl_o(ctl), .acc_o(acc), .imm_o(imm),
    .lit_o(lit), .val_o(val), .pulse_o(pulse));

  cpu_register_set dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .wb_i(wb), .ctl_i(ctl),
    .mac_we_i(pulse[0]), .mac_result_i(val), .call_i(pulse[1]), .call_ret_i(val[31:0]),
    .pc_we_i(pulse[2]), .pc_next_i(val[31:0]), .boot_load_i(pulse[5]),
    .boot_sp_i(val[63:32]), .boot_pc_i(val[31:0]), .exc_push_i(pulse[3]),
    .exc_pop_i(pulse[4]), .acc_i(acc), .imm_i(imm), .lit_i(lit), .rd_a_idx_i(ra_idx),
    .rd_b_idx_i(rb_idx), .rd_a_o(rd_a), .rd_b_o(rd_b), .index_o(index), .sp_o(sp),
    .status_o(status), .gbase_o(gbase), .vbase_o(vbase), .acch_o(acch), .accl_o(accl),
    .link_o(link), .pc_o(pc), .imm_ext_o(imm_ext), .lit_addr_o(lit_addr),
    .addr_err_o(addr_err), .irq_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~d;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    chk(status, 32'h0000_00F0);
    chk(vbase, 32'h0000_0000);
    rst_b <= 1'b1;
    rd_chk(cpu_regs_pkg::OFS_STATUS, 32'h0000_00F0);
    rd_chk(cpu_regs_pkg::OFS_VBASE, 32'h0000_0000);
    pm.pulse(6'h20, 64'h0000_1000_0000_0206);
    chk(sp, 32'h0000_1000);
    chk(pc, 32'h0000_0206);
    rd_chk(8'h3C, 32'h0000_1000);
    // Word literal keeps pc alignment, long literal drops the low two bits
    pm.ext('{logic_op: 1'b0, val: 8'h80}, '{is_long: 1'b1, disp: 8'h02});
    chk(imm_ext, 32'hFFFF_FF80);
    chk(lit_addr, 32'h0000_0210);
    pm.ext('{logic_op: 1'b1, val: 8'h80}, '{is_long: 1'b0, disp: 8'h03});
    chk(imm_ext, 32'h0000_0080);
    chk(lit_addr, 32'h0000_0210);
    for (int i = 0; i < 16; i++) begin
      bus_wr(8'(i * 4), 32'hA5C3_0000 | 32'(i));
    end
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'(i * 4), 32'hA5C3_0000 | 32'(i));
    end
    chk(index, 32'hA5C3_0000);
    chk(sp, 32'hA5C3_000F);
    for (int k = 0; k < 5; k++) begin
      pm.wb(4'h3, cpu_regs_pkg::wb_kind_t'(k), din[k]);
      chk(rd_a, dex[k]);
    end
    chk(rd_b, 32'hA5C3_0000);
    pm.ctl(cpu_regs_pkg::CTL_STATUS, 32'hFFFF_FFFF);
    chk(status, cpu_regs_pkg::SR_WRITABLE);
    pm.ctl(cpu_regs_pkg::CTL_GBASE, 32'h0400_0000);
    chk(gbase, 32'h0400_0000);
    pm.ctl(cpu_regs_pkg::CTL_VBASE, 32'h0000_1000);
    rd_chk(cpu_regs_pkg::OFS_VBASE, 32'h0000_1000);
    pm.pulse(6'h01, 64'h1111_2222_3333_4444);
    chk(acch, 32'h1111_2222);
    chk(accl, 32'h3333_4444);
    pm.pulse(6'h02, 64'h0000_0000_0000_0500);
    chk(link, 32'h0000_0500);
    pm.pulse(6'h04, 64'h0000_0000_0000_0600);
    bus_wr(cpu_regs_pkg::OFS_PC, 32'hDEAD_0000);
    rd_chk(cpu_regs_pkg::OFS_PC, 32'h0000_0600);
    bus_wr(8'h80, 32'h0000_0001);
    rd_chk(8'h80, 32'h0000_0000);
    for (int j = 0; j < 6; j++) begin
      pm.acc(ast[j], cpu_regs_pkg::acc_size_t'(asz[j]), aad[j]);
      chk1(addr_err, aer[j]);
    end
    @(posedge mclk);
    #1;
    chk1(addr_err, 1'b0);
    // Events are sticky until read; irq follows status and mask
    rd_chk(cpu_regs_pkg::OFS_EVT, 32'h0000_0003);
    bus_wr(cpu_regs_pkg::OFS_EVT_MASK, 32'h0000_0000);
    pm.acc(1'b0, cpu_regs_pkg::SZ_HALF, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk1(irq, 1'b0);
    bus_wr(cpu_regs_pkg::OFS_EVT_MASK, 32'h0000_0003);
    repeat (2) @(posedge mclk);
    chk1(irq, 1'b1);
    rd_chk(cpu_regs_pkg::OFS_EVT, 32'h0000_0001);
    @(posedge mclk);
    #1;
    chk1(irq, 1'b0);
    rd_chk(cpu_regs_pkg::OFS_EVT, 32'h0000_0000);
    pm.pulse(6'h20, 64'h0000_1000_0000_0100);
    pm.pulse(6'h08, 64'h0);
    chk(sp, 32'h0000_0FF8);
    pm.pulse(6'h10, 64'h0);
    chk(sp, 32'h0000_1000);
    pm.pulse(6'h20, 64'h0000_1002_0000_0100);
    pm.pulse(6'h08, 64'h0);
    rd_chk(cpu_regs_pkg::OFS_EVT, 32'h0000_0002);
    // A reset in mid-run must restore the vbase and status written above; quiet inputs first
    pm.ext('{logic_op: 1'b0, val: 8'h00}, '{is_long: 1'b0, disp: 8'h00});
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(vbase, 32'h0000_0000);
    chk(status, 32'h0000_00F0);
    @(posedge mclk);
    rst_b <= 1'b1;
    rd_chk(cpu_regs_pkg::OFS_VBASE, 32'h0000_0000);
    rd_chk(cpu_regs_pkg::OFS_STATUS, 32'h0000_00F0);
    wrap_up();
  end
endmodule

// *** verification/pipe_model.sv ***
// Pipeline-side partner: issues one-cycle requests, except held ext requests, to the register set.
// Assumes callers share mclk_i and wait for each task to return.
module pipe_model (
  input wire logic mclk_i,
  output cpu_regs_pkg::wb_req_t wb_o,
  output cpu_regs_pkg::ctl_req_t ctl_o,
  output cpu_regs_pkg::acc_req_t acc_o,
  output cpu_regs_pkg::imm_req_t imm_o,
  output cpu_regs_pkg::lit_req_t lit_o,
  output logic [63:0] val_o,
  output logic [5:0] pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wb_o = '0;
    ctl_o = '0;
    acc_o = '0;
    imm_o = '0;
    lit_o = '0;
    val_o = '0;
    pulse_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released data is inverted, so a stale value is never mistaken for a live one
  task automatic wb(input logic [3:0] i, input cpu_regs_pkg::wb_kind_t k, input logic [31:0] d);
    @(posedge mclk_i);
    wb_o <= '{en: 1'b1, idx: i, kind: k, data: d};
    @(posedge mclk_i);
    wb_o <= '{en: 1'b0, idx: ~i, kind: k, data: ~d};
    #1;
  endtask

  task automatic ctl(input cpu_regs_pkg::ctl_sel_t s, input logic [31:0] d);
    @(posedge mclk_i);
    ctl_o <= '{en: 1'b1, sel: s, data: d};
    @(posedge mclk_i);
    ctl_o <= '{en: 1'b0, sel: s, data: ~d};
    #1;
  endtask

  task automatic acc(input logic stk, input cpu_regs_pkg::acc_size_t z, input logic [31:0] a);
    @(posedge mclk_i);
    acc_o <= '{valid: 1'b1, stack: stk, size: z, addr: a};
    @(posedge mclk_i);
    acc_o <= '{valid: 1'b0, stack: ~stk, size: z, addr: ~a};
    #1;
  endtask

  // Pulse bits: 0 mac, 1 call, 2 pc, 3 push, 4 pop, 5 boot
  task automatic pulse(input logic [5:0] p, input logic [63:0] v);
    @(posedge mclk_i);
    pulse_o <= p;
    val_o <= v;
    @(posedge mclk_i);
    pulse_o <= 6'h00;
    val_o <= ~v;
    #1;
  endtask

  task automatic ext(input cpu_regs_pkg::imm_req_t i, input cpu_regs_pkg::lit_req_t l);
    @(posedge mclk_i);
    imm_o <= i;
    lit_o <= l;
    @(posedge mclk_i);
    #1;
  endtask
endmodule
